// *** design/anar_pkg.sv ***
// anar_pkg: offsets, field layouts, reset values and carrier types for the
// auto-negotiation ability register bank.
// assumes a single 50 MHz management clock and a 32-bit Avalon-MM slave port.
// What this block does
// (RL1) two offsets decode per active mode
// (RL2) 1000X advert writes wait for apply event
// (RL3) 1000X advert bits 4:0 writable, reset zero
// (RL4) media advert bit 15 shows interface link
// (RL5) media advert bit 12 shows resolved duplex
// (RL6) media advert bits 11:10 show interface speed
// (RL7) media advert 6:0 fixed 0000001, 14:13 zero
// (RL8) system advert constant 0x0001 after resets
// (RL9) 1000X partner fields clear on link down
// (RL10) partner bit 15 is next page ability
// (RL11) partner bit 14 is acknowledge
// (RL12) partner bits 13:12 remote fault code
// (RL13) partner bits 8:7 pause ability
// (RL14) partner bits 6,5 half/full duplex ability
// (RL15) reserved partner bits mirror code word
// (RL16) media partner 15 zero, 13:0 as received
// (RL17) page received flag latches, clears on read
// (RL18) clear beats load, never both together
`default_nettype none
package anar_pkg;
    // printed register indices; byte address is index times four
    localparam logic [13:0] IDX_ADV = 14'h2004;
    localparam logic [13:0] IDX_LP = 14'h2005;
    localparam logic [13:0] IDX_EXP = 14'h2006;
    localparam logic [13:0] IDX_MODE = 14'h2010;
    localparam logic [13:0] IDX_IRQ_STS = 14'h2011;
    localparam logic [13:0] IDX_IRQ_MSK = 14'h2012;

    typedef enum logic [1:0] {
        ANAR_MODE_X = 2'h0,
        ANAR_MODE_SG_MEDIA = 2'h1,
        ANAR_MODE_SG_SYS = 2'h2
    } anar_mode_t;
    localparam logic [1:0] MODE_RST = 2'h0;

    // 1000X advertisement: software-writable bits and fixed ones
    localparam logic [15:0] ADV_X_WMASK = 16'hB19F;
    localparam logic [15:0] ADV_X_RST = 16'h0020;
    localparam logic [15:0] ADV_SYS_VAL = 16'h0001;
    localparam logic [6:0] ADV_MEDIA_LOW = 7'h01;
    localparam logic [15:0] LP_RST = 16'h0000;

    // expansion register bits
    localparam int EXP_PAGE_RX_BIT = 1;
    localparam int EXP_LP_NP_BIT = 3;

    // interrupt status and mask layout
    localparam int IRQ_W = 2;
    localparam int IRQ_PAGE_BIT = 0;
    localparam int IRQ_LINK_DOWN_BIT = 1;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

    typedef enum logic [1:0] {
        ANAR_BUS_IDLE = 2'b01,
        ANAR_BUS_ACK = 2'b10
    } anar_bus_st_t;

    // attached interface status shown in the media-side advertisement
    typedef struct packed {
        logic link_up;
        logic full_duplex;
        logic [1:0] speed;
        logic tx_pause;
        logic rx_pause;
        logic fiber;
    } anar_if_sts_t;

    // strobes from the port's negotiation state machine
    typedef struct packed {
        logic sw_reset;
        logic an_restart;
        logic power_up;
        logic link_down;
        logic page_rx;
        logic [15:0] rx_word;
    } anar_evt_t;
endpackage : anar_pkg
`default_nettype wire

// *** design/anar_regs.sv ***
// anar_regs: per-port advertisement and link partner ability registers
// behind an Avalon-MM slave with waitrequest.
// assumes event strobes and interface status come from logic on sys_clk.
`default_nettype none
module anar_regs #(
    parameter int ADDR_W = 16
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire anar_pkg::anar_if_sts_t if_sts,
    input wire anar_pkg::anar_evt_t evt,
    output logic [15:0] tx_cfg_word,
    output logic [15:0] lp_ability,
    output logic irq
);
    typedef struct packed {
        anar_pkg::anar_bus_st_t st;
        logic waitreq;
        logic [15:0] rdata;
        logic [1:0] mode;
        logic [15:0] adv_pend;
        logic [15:0] adv_act;
        logic [15:0] lp;
        logic page_rx;
        logic lp_np;
        logic [anar_pkg::IRQ_W-1:0] irq_sts;
        logic [anar_pkg::IRQ_W-1:0] irq_msk;
        logic irq;
        logic [15:0] tx_word;
    } anar_state_t;

    anar_state_t s_r;
    anar_state_t s_nxt;

    function automatic logic anar_hit(input logic [ADDR_W-1:0] a, input logic [13:0] idx);
        anar_hit = (a[ADDR_W-1:2] == idx[ADDR_W-3:0]) && (a[1:0] == 2'h0);
    endfunction : anar_hit

    // merges the two low byte lanes of a write into a 16-bit value
    function automatic logic [15:0] anar_wmerge(input logic [15:0] old, input logic [31:0] wd,
                                                input logic [3:0] be);
        anar_wmerge = old;
        if (be[0]) begin
            anar_wmerge[7:0] = wd[7:0];
        end
        if (be[1]) begin
            anar_wmerge[15:8] = wd[15:8];
        end
    endfunction : anar_wmerge

    logic req;
    logic take;
    logic wr_take;
    logic rd_take;
    logic apply_adv;
    logic lp_clear;
    logic lp_load;
    logic [15:0] media_adv;
    logic [15:0] adv_view;
    logic [15:0] lp_view;
    logic [15:0] rd_mux;

    always_comb begin
        req = avs_read | avs_write;
        // the request is accepted at the edge where waitrequest is seen low
        take = req && (s_r.st == anar_pkg::ANAR_BUS_ACK);
        wr_take = take && avs_write;
        rd_take = take && avs_read;

        // pending advertisement goes live only on these events
        apply_adv = evt.sw_reset | evt.an_restart | evt.power_up | evt.link_down; // RL2
        // clear wins, so load and clear never land in one cycle
        lp_clear = evt.link_down | evt.sw_reset; // RL9 RL18
        lp_load = evt.page_rx & ~lp_clear; // RL18

        media_adv = {if_sts.link_up, // RL4
                     2'h0, // RL7
                     if_sts.full_duplex, // RL5
                     if_sts.speed, // RL6
                     if_sts.tx_pause,
                     if_sts.rx_pause,
                     if_sts.fiber,
                     anar_pkg::ADV_MEDIA_LOW}; // RL7

        case (s_r.mode) // RL1
            anar_pkg::ANAR_MODE_X: begin
                adv_view = s_r.adv_pend;
                lp_view = s_r.lp; // RL10 RL11 RL12 RL13 RL14 RL15
            end
            anar_pkg::ANAR_MODE_SG_MEDIA: begin
                adv_view = media_adv;
                lp_view = {1'b0, s_r.lp[14:0]}; // RL11 RL16
            end
            anar_pkg::ANAR_MODE_SG_SYS: begin
                adv_view = anar_pkg::ADV_SYS_VAL; // RL8
                lp_view = s_r.lp;
            end
            default: begin
                adv_view = 16'h0000;
                lp_view = 16'h0000;
            end
        endcase

        rd_mux = 16'h0000;
        if (anar_hit(avs_address, anar_pkg::IDX_ADV)) begin
            rd_mux = adv_view;
        end else if (anar_hit(avs_address, anar_pkg::IDX_LP)) begin
            rd_mux = lp_view;
        end else if (anar_hit(avs_address, anar_pkg::IDX_EXP)) begin
            rd_mux[anar_pkg::EXP_PAGE_RX_BIT] = s_r.page_rx;
            rd_mux[anar_pkg::EXP_LP_NP_BIT] = s_r.lp_np;
        end else if (anar_hit(avs_address, anar_pkg::IDX_MODE)) begin
            rd_mux[1:0] = s_r.mode;
        end else if (anar_hit(avs_address, anar_pkg::IDX_IRQ_STS)) begin
            rd_mux[anar_pkg::IRQ_W-1:0] = s_r.irq_sts;
        end else if (anar_hit(avs_address, anar_pkg::IDX_IRQ_MSK)) begin
            rd_mux[anar_pkg::IRQ_W-1:0] = s_r.irq_msk;
        end
    end

    always_comb begin
        s_nxt = s_r;

        // bus handshake: one wait cycle, then one cycle with waitrequest low
        case (s_r.st)
            anar_pkg::ANAR_BUS_IDLE: begin
                if (req) begin
                    s_nxt.st = anar_pkg::ANAR_BUS_ACK;
                    s_nxt.waitreq = 1'b0;
                    s_nxt.rdata = avs_read ? rd_mux : 16'h0000;
                end
            end
            anar_pkg::ANAR_BUS_ACK: begin
                s_nxt.st = anar_pkg::ANAR_BUS_IDLE;
                s_nxt.waitreq = 1'b1;
            end
            default: begin
                s_nxt.st = anar_pkg::ANAR_BUS_IDLE;
                s_nxt.waitreq = 1'b1;
            end
        endcase

        // software writes
        if (wr_take && anar_hit(avs_address, anar_pkg::IDX_ADV) && s_r.mode == anar_pkg::ANAR_MODE_X) begin
            s_nxt.adv_pend = (anar_wmerge(s_r.adv_pend, avs_writedata, avs_byteenable)
                              & anar_pkg::ADV_X_WMASK)
                             | (anar_pkg::ADV_X_RST & ~anar_pkg::ADV_X_WMASK); // RL2 RL3
        end
        if (wr_take && anar_hit(avs_address, anar_pkg::IDX_MODE) && avs_byteenable[0]) begin
            s_nxt.mode = avs_writedata[1:0];
        end
        if (wr_take && anar_hit(avs_address, anar_pkg::IDX_IRQ_MSK) && avs_byteenable[0]) begin
            s_nxt.irq_msk = avs_writedata[anar_pkg::IRQ_W-1:0];
        end
        if (wr_take && anar_hit(avs_address, anar_pkg::IDX_IRQ_STS) && avs_byteenable[0]) begin
            s_nxt.irq_sts = s_r.irq_sts & ~avs_writedata[anar_pkg::IRQ_W-1:0];
        end

        // reading the expansion word clears only what that read reported
        if (rd_take && anar_hit(avs_address, anar_pkg::IDX_EXP)) begin
            s_nxt.page_rx = s_r.page_rx & ~s_r.rdata[anar_pkg::EXP_PAGE_RX_BIT]; // RL17
        end

        if (apply_adv) begin
            s_nxt.adv_act = s_nxt.adv_pend; // RL2
        end

        // partner capture
        if (lp_clear) begin
            s_nxt.lp = anar_pkg::LP_RST; // RL9
            s_nxt.lp_np = 1'b0;
        end else if (lp_load) begin
            s_nxt.lp = evt.rx_word; // RL9 RL10 RL11 RL12 RL13 RL14 RL15 RL16
            s_nxt.lp_np = (s_r.mode == anar_pkg::ANAR_MODE_X) & evt.rx_word[15];
        end
        if (evt.sw_reset) begin
            s_nxt.page_rx = 1'b0;
        end

        // events set after clears so a same-cycle event is kept
        if (lp_load) begin
            s_nxt.page_rx = 1'b1; // RL17
            s_nxt.irq_sts[anar_pkg::IRQ_PAGE_BIT] = 1'b1;
        end
        if (evt.link_down) begin
            s_nxt.irq_sts[anar_pkg::IRQ_LINK_DOWN_BIT] = 1'b1;
        end
        s_nxt.irq = |(s_nxt.irq_sts & s_nxt.irq_msk);

        // word handed to the transmit side of negotiation
        case (s_nxt.mode) // RL1
            anar_pkg::ANAR_MODE_X: s_nxt.tx_word = s_nxt.adv_act;
            anar_pkg::ANAR_MODE_SG_MEDIA: s_nxt.tx_word = media_adv;
            anar_pkg::ANAR_MODE_SG_SYS: s_nxt.tx_word = anar_pkg::ADV_SYS_VAL; // RL8
            default: s_nxt.tx_word = anar_pkg::ADV_SYS_VAL;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_r.st <= anar_pkg::ANAR_BUS_IDLE;
            s_r.waitreq <= 1'b1;
            s_r.rdata <= 16'h0000;
            s_r.mode <= anar_pkg::MODE_RST;
            s_r.adv_pend <= anar_pkg::ADV_X_RST; // RL3
            s_r.adv_act <= anar_pkg::ADV_X_RST;
            s_r.lp <= anar_pkg::LP_RST;
            s_r.page_rx <= 1'b0;
            s_r.lp_np <= 1'b0;
            s_r.irq_sts <= anar_pkg::IRQ_RST;
            s_r.irq_msk <= anar_pkg::IRQ_RST;
            s_r.irq <= 1'b0;
            s_r.tx_word <= anar_pkg::ADV_X_RST;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    assign avs_readdata = {16'h0000, s_r.rdata};
    assign avs_waitrequest = s_r.waitreq;
    assign tx_cfg_word = s_r.tx_word;
    assign lp_ability = s_r.lp;
    assign irq = s_r.irq;
endmodule : anar_regs
`default_nettype wire

// *** dv/anar_regs_checker.sv ***
// anar_regs_checker: port-level assertions for the ability register bank.
// assumes one sys_clk domain; bound onto every anar_regs instance.
`default_nettype none
module anar_regs_checker (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire anar_pkg::anar_if_sts_t if_sts,
    input wire anar_pkg::anar_evt_t evt,
    input wire logic [15:0] tx_cfg_word,
    input wire logic [15:0] lp_ability,
    input wire logic irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire logic clr = evt.link_down | evt.sw_reset;
    // a mode write or apply event reaches tx_cfg_word at the edge that takes it
    wire logic quiet = !(clr | evt.an_restart | evt.power_up | avs_write);
    sequence req_s;
        clk_en && (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence ack_s;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    chk_bus_ack: assert property (req_s |=> ack_s) else $error("bus answer late");
    chk_rd_upper: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
        else $error("read upper half set");
    chk_lp_load: assert property (clk_en && evt.page_rx && !clr |=> lp_ability == $past(evt.rx_word))
        else $error("page not captured");
    chk_lp_clear: assert property (clk_en && clr |=> lp_ability == 16'h0000)
        else $error("partner word kept");
    chk_lp_hold: assert property (clk_en && !evt.page_rx && !clr |=> $stable(lp_ability))
        else $error("partner word moved");
    chk_adv_hold: assert property (clk_en && quiet && $past(quiet) && $stable(if_sts) |=> $stable(tx_cfg_word))
        else $error("advert moved early");
    chk_adv_b14: assert property (tx_cfg_word[14] == 1'b0) else $error("advert bit 14 set");
    chk_irq_rise: assert property ($rose(irq) |-> $past(evt.page_rx | clr | avs_write, 1)
        || $past(evt.page_rx | clr | avs_write, 2)) else $error("irq without cause");
endmodule : anar_regs_checker
bind anar_regs anar_regs_checker u_chk (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .if_sts(if_sts), .evt(evt), .tx_cfg_word(tx_cfg_word), .lp_ability(lp_ability), .irq(irq));
`default_nettype wire

// *** dv/anar_lp_model.sv ***
// anar_lp_model: remote partner handing received base pages to the bank.
// assumes go is a one-cycle request raised just after a sys_clk edge.
`default_nettype none
module anar_lp_model (
    input wire logic sys_clk,
    input wire logic go,
    input wire logic [15:0] word,
    input wire logic [3:0] gap,
    output logic page_rx = 1'b0,
    output logic [15:0] rx_word = 16'h0000,
    output logic busy
);
    logic [4:0] cnt_r = 5'h00;
    logic [15:0] w_r = 16'h0000;
    assign busy = (cnt_r != 5'h00) || page_rx;
    always @(posedge sys_clk) begin
        page_rx <= 1'b0;
        // word lines carry junk outside a page
        rx_word <= ~rx_word;
        if (cnt_r != 5'h00) begin
            cnt_r <= cnt_r - 5'h01;
            if (cnt_r == 5'h01) begin
                page_rx <= 1'b1;
                rx_word <= w_r;
            end
        end else if (go) begin
            cnt_r <= {1'b0, gap} + 5'h01;
            w_r <= word;
        end
    end
endmodule : anar_lp_model
`default_nettype wire

// *** dv/anar_regs_tb.sv ***
// anar_regs_tb: directed bench for the ability register bank.
// assumes anar_pkg, anar_regs and anar_lp_model are compiled first.
`default_nettype none
module anar_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, avs_read = 1'b0, avs_write = 1'b0, lp_go = 1'b0;
    logic avs_waitrequest, page_rx, busy, irq;
    logic [15:0] avs_address = 16'h0000, lp_word = 16'h0000, rx_word, tx_cfg_word, lp_ability, q;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
    logic [3:0] avs_byteenable = 4'h3, ctl = 4'h0, lp_gap = 4'h0;
    anar_pkg::anar_if_sts_t if_sts = '0;
    anar_pkg::anar_evt_t evt;
    int miscompares = 0, tests_run = 0;
    assign evt = {ctl, page_rx, rx_word};
    initial forever #10 sys_clk = ~sys_clk;
    anar_regs dut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .if_sts(if_sts), .evt(evt),
        .tx_cfg_word(tx_cfg_word), .lp_ability(lp_ability), .irq(irq));
    anar_lp_model u_lp (.sys_clk(sys_clk), .go(lp_go), .word(lp_word), .gap(lp_gap), .page_rx(page_rx),
        .rx_word(rx_word), .busy(busy));
    task automatic conclude();
        if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tmo(input int n);
        if (n >= 40) begin
            miscompares++;
            conclude();
        end
    endtask : tmo
    // every access starts after a rising edge and returns at a falling one
    task automatic bus(input logic w, input logic [13:0] idx, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {16'h0000, d};
        avs_write <= w;
        avs_read <= !w;
        // waitrequest and read data are taken as they stood at the rising edge
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        tmo(n);
        q = avs_readdata[15:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(negedge sys_clk);
    endtask : bus
    task automatic rd(input logic [13:0] idx, input logic [15:0] exp);
        bus(1'b0, idx, 16'h0000);
        chk(q, exp);
    endtask : rd
    task automatic pulse(input logic [3:0] c);
        @(posedge sys_clk);
        ctl <= c;
        @(posedge sys_clk);
        ctl <= 4'h0;
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : pulse
    // clash lines a link loss up with the page strobe
    task automatic page(input logic [15:0] w, input logic [3:0] g, input logic clash);
        int n;
        n = 0;
        @(posedge sys_clk);
        lp_word <= w;
        lp_gap <= g;
        lp_go <= 1'b1;
        @(posedge sys_clk);
        lp_go <= 1'b0;
        if (clash) pulse(4'h1);
        // busy rises only once the model has taken go, so look at the next falling edge first
        do begin
            @(negedge sys_clk);
            n++;
        end while (busy && n < 40);
        tmo(n);
    endtask : page
    task automatic t_pend();
        logic [15:0] d, e, p;
        p = anar_pkg::ADV_X_RST;
        for (int i = 0; i < 4; i++) begin
            d = 16'hFFE0 | (16'h0001 << i);
            e = (d & anar_pkg::ADV_X_WMASK) | anar_pkg::ADV_X_RST;
            bus(1'b1, anar_pkg::IDX_ADV, d);
            chk(tx_cfg_word, p);
            rd(anar_pkg::IDX_ADV, e);
            pulse(4'h8 >> i);
            chk(tx_cfg_word, e);
            p = e;
        end
    endtask : t_pend
    task automatic t_lpx();
        logic [15:0] w;
        for (int i = 0; i < 4; i++) begin
            w = (16'(i) << 12) | (16'(i) << 7) | (i[0] ? 16'h8E60 : 16'h401F);
            page(w, 4'(3 * i), 1'b0);
            rd(anar_pkg::IDX_LP, w);
            bus(1'b0, anar_pkg::IDX_EXP, 16'h0000);
            chk(q & 16'h000A, {12'h000, w[15], 3'h2});
            bus(1'b0, anar_pkg::IDX_EXP, 16'h0000);
            chk(q & 16'h0002, 16'h0000);
        end
        pulse(4'h1);
        rd(anar_pkg::IDX_LP, 16'h0000);
        page(16'hFFFF, 4'h0, 1'b1);
        chk(lp_ability, 16'h0000);
    endtask : t_lpx
    task automatic t_irq();
        bus(1'b1, anar_pkg::IDX_IRQ_STS, 16'h0003);
        bus(1'b1, anar_pkg::IDX_IRQ_MSK, 16'h0000);
        page(16'h0020, 4'h0, 1'b0);
        chk({15'h0000, irq}, 16'h0000);
        rd(anar_pkg::IDX_IRQ_STS, 16'h0001);
        bus(1'b1, anar_pkg::IDX_IRQ_MSK, 16'h0001);
        chk({15'h0000, irq}, 16'h0001);
        bus(1'b1, anar_pkg::IDX_IRQ_STS, 16'h0001);
        chk({15'h0000, irq}, 16'h0000);
    endtask : t_irq
    task automatic t_media();
        logic [15:0] e;
        bus(1'b1, anar_pkg::IDX_MODE, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            if_sts <= {i[0], i[1], i[1:0], i[0], i[1], i[0]};
            e = {i[0], 2'b00, i[1], i[1:0], i[0], i[1], i[0], 7'h01};
            rd(anar_pkg::IDX_ADV, e);
            chk(tx_cfg_word, e);
        end
        bus(1'b1, anar_pkg::IDX_ADV, 16'hFFFF);
        rd(anar_pkg::IDX_ADV, e);
        page(16'hC001, 4'h5, 1'b0);
        rd(anar_pkg::IDX_LP, 16'h4001);
    endtask : t_media
    task automatic t_sys();
        bus(1'b1, anar_pkg::IDX_MODE, 16'h0002);
        bus(1'b1, anar_pkg::IDX_ADV, 16'hFFFE);
        pulse(4'h8);
        rd(anar_pkg::IDX_ADV, anar_pkg::ADV_SYS_VAL);
        chk(tx_cfg_word, anar_pkg::ADV_SYS_VAL);
    endtask : t_sys
    initial begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        @(negedge sys_clk);
        chk(lp_ability, 16'h0000);
        rd(anar_pkg::IDX_ADV, anar_pkg::ADV_X_RST);
        rd(14'h2020, 16'h0000);
        t_pend();
        t_lpx();
        t_irq();
        t_media();
        t_sys();
        conclude();
    end
endmodule : anar_regs_tb
`default_nettype wire
